// File: tgn_pkg.sv
// Package for the amplifier gain network configuration bank.
// Assumes a 32-bit classic Wishbone bus and byte addresses as printed.
package tgn_pkg;

  localparam int ADDR_W = 16;
  localparam int DATA_W = 32;
  localparam int SEL_W = 4;
  localparam int NUM_REGS = 3;

  // Byte addresses of the three registers
  localparam logic [15:0] GAIN_NET_OFFSET = 16'h20F0;
  localparam logic [15:0] ELEC_PATH_OFFSET = 16'h20F8;
  localparam logic [15:0] BIAS_SEL_OFFSET = 16'h20FC;

  // Reset values
  localparam logic [31:0] GAIN_NET_RESET = 32'h0000000F;
  localparam logic [31:0] ELEC_PATH_RESET = 32'h000000FF;
  localparam logic [31:0] BIAS_SEL_RESET = 32'h00000000;

  // Writable bits; all others are reserved and read zero
  localparam logic [31:0] GAIN_NET_WMASK = 32'h00001FFF;
  localparam logic [31:0] ELEC_PATH_WMASK = 32'h000000FF;
  localparam logic [31:0] BIAS_SEL_WMASK = 32'h00000003;

  // Field positions in the gain network register, then the electrode path and bias select field widths
  localparam int GAIN_RES_LSB = 0;
  localparam int GAIN_RES_W = 4;
  localparam int DIODE_SW_BIT = 4;
  localparam int FB_CAP_LSB = 5;
  localparam int FB_CAP_W = 8;
  localparam int ELEC_RES_W = 8;
  localparam int BIAS_SEL_W = 2;
  localparam int GAIN_STEPS = 8;

  // Special electrode path codes
  localparam logic [7:0] ELEC_DISCONNECT = 8'hFF;
  localparam logic [7:0] ELEC_SHORT_BOTH = 8'h97;

  // Positive input select codes
  localparam logic [1:0] BIAS_INTERNAL = 2'h0;
  localparam logic [1:0] BIAS_DAC_ZERO = 2'h1;

  // Feedback capacitor in pF, five bits wide
  localparam logic [4:0] CAP_1PF = 5'h01;
  localparam logic [4:0] CAP_2PF = 5'h02;
  localparam logic [4:0] CAP_4PF = 5'h04;
  localparam logic [4:0] CAP_8PF = 5'h08;
  localparam logic [4:0] CAP_16PF = 5'h10;

  localparam logic [31:0] UNMAPPED_READ = 32'h00000000;

  typedef struct packed {
    logic cyc;
    logic stb;
    logic we;
    logic [ADDR_W-1:0] adr;
    logic [SEL_W-1:0] sel;
    logic [DATA_W-1:0] dat;
  } tgn_wb_req_t;

  // Decoded analog switch controls
  typedef struct packed {
    logic [GAIN_STEPS-1:0] gain_res_en;
    logic gain_res_open;
    logic diode_sw_on;
    logic [4:0] fb_cap_pf;
    logic fb_cap_unused;
    logic [ELEC_RES_W-1:0] elec_res_code;
    logic elec_disconnect;
    logic elec_short_both;
    logic bias_internal_en;
    logic bias_dac_zero_en;
    logic bias_reserved;
  } tgn_analog_t;

  typedef enum logic [1:0] {
    TGN_IDLE = 2'b01,
    TGN_ACK = 2'b10
  } tgn_bus_state_t;

endpackage

// File: tgn_reg_slot.sv
// One configuration register with a reset value and a writable-bit mask.
// Assumes the caller qualifies wr_i with the bus handshake.
`timescale 1ns/10ps
module tgn_reg_slot #(
  parameter logic [31:0] RESET_VAL = 32'h00000000,
  parameter logic [31:0] WMASK = 32'hFFFFFFFF
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic ce_i,
  input wire logic wr_i,
  input wire logic [3:0] sel_i,
  input wire logic [31:0] wdata_i,
  output logic [31:0] q_o
);

  logic [31:0] value;
  logic [31:0] next_value;
  logic [31:0] lane_mask;

  always_comb begin
    lane_mask = {{8{sel_i[3]}}, {8{sel_i[2]}}, {8{sel_i[1]}}, {8{sel_i[0]}}} & WMASK;
    next_value = value;
    if (wr_i) begin
      next_value = (value & ~lane_mask) | (wdata_i & lane_mask);
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      value <= RESET_VAL;
    end else if (ce_i) begin
      value <= next_value;
    end
  end

  assign q_o = value & WMASK;

endmodule

// File: tgn_config_bank.sv
// Configuration bank of the high speed amplifier gain network, with a
// classic Wishbone slave and decoded analog switch controls.
// Assumes the bus master holds a request until it sees ack.
// Function
// - Gain resistor codes 0 to 7 each close one resistor, codes 8 and up leave it open.
// - The gain network register resets to 0x0000000F.
// - The feedback capacitor field maps 0,1,2,4,8,16 to 1,2,4,8,16,2 pF, the top codes unused.
// - Bit 4 set closes the diode switch across the gain resistor, clear keeps it open.
// - The electrode path field resets to 0xFF, both resistors off; software sets T9/T10 first.
// - Bias select 00 picks the internal bias node, 01 the DAC zero output, others reserved.
// - The bias select register resets to all zeros.
// - Electrode path code 0x97 shorts both the load and gain resistors.
//
// Chosen here: register access over Wishbone.
`timescale 1ns/10ps
module tgn_config_bank (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic ce_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [tgn_pkg::ADDR_W-1:0] wb_adr_i,
  input wire logic [tgn_pkg::SEL_W-1:0] wb_sel_i,
  input wire logic [tgn_pkg::DATA_W-1:0] wb_dat_i,
  output logic [tgn_pkg::DATA_W-1:0] wb_dat_o,
  output logic wb_ack_o,
  output tgn_pkg::tgn_analog_t analog_o
);

  localparam logic [15:0] OFFSETS [tgn_pkg::NUM_REGS] = '{
    tgn_pkg::GAIN_NET_OFFSET, tgn_pkg::ELEC_PATH_OFFSET, tgn_pkg::BIAS_SEL_OFFSET};
  localparam logic [31:0] RESETS [tgn_pkg::NUM_REGS] = '{
    tgn_pkg::GAIN_NET_RESET, tgn_pkg::ELEC_PATH_RESET, tgn_pkg::BIAS_SEL_RESET};
  localparam logic [31:0] WMASKS [tgn_pkg::NUM_REGS] = '{
    tgn_pkg::GAIN_NET_WMASK, tgn_pkg::ELEC_PATH_WMASK, tgn_pkg::BIAS_SEL_WMASK};

  tgn_pkg::tgn_wb_req_t req;
  tgn_pkg::tgn_bus_state_t state;
  tgn_pkg::tgn_bus_state_t next_state;
  logic [tgn_pkg::DATA_W-1:0] rdata;
  logic [tgn_pkg::DATA_W-1:0] next_rdata;
  logic [tgn_pkg::NUM_REGS-1:0] hit;
  logic [tgn_pkg::NUM_REGS-1:0] wr;
  logic [31:0] regq [tgn_pkg::NUM_REGS];
  logic [31:0] read_mux;
  tgn_pkg::tgn_analog_t analog;
  tgn_pkg::tgn_analog_t next_analog;

  assign req = '{cyc: wb_cyc_i, stb: wb_stb_i, we: wb_we_i, adr: wb_adr_i,
                 sel: wb_sel_i, dat: wb_dat_i};

  // Resets of the three registers come from the slot parameters
  genvar g;
  generate
    for (g = 0; g < tgn_pkg::NUM_REGS; g++) begin : g_regs
      assign hit[g] = (req.adr == OFFSETS[g]);
      // Write lands on the edge where the master samples ack
      assign wr[g] = hit[g] && req.we && req.cyc && req.stb && (state == tgn_pkg::TGN_ACK);
      tgn_reg_slot #(
        .RESET_VAL(RESETS[g]),
        .WMASK(WMASKS[g])
      ) u_slot (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .ce_i(ce_i),
        .wr_i(wr[g]),
        .sel_i(req.sel),
        .wdata_i(req.dat),
        .q_o(regq[g])
      );
    end
  endgenerate

  // Unmapped addresses are acked and read zero, writes to them are dropped
  always_comb begin
    read_mux = tgn_pkg::UNMAPPED_READ;
    for (int i = 0; i < tgn_pkg::NUM_REGS; i++) begin
      if (hit[i]) begin
        read_mux = regq[i];
      end
    end
  end

  // Bus handshake: request seen in idle, ack one cycle later for one cycle
  always_comb begin
    next_state = state;
    next_rdata = rdata;
    unique case (state)
      tgn_pkg::TGN_IDLE: begin
        if (req.cyc && req.stb) begin
          next_state = tgn_pkg::TGN_ACK;
          next_rdata = read_mux;
        end
      end
      tgn_pkg::TGN_ACK: begin
        next_state = tgn_pkg::TGN_IDLE;
      end
      default: begin
        next_state = tgn_pkg::TGN_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state <= tgn_pkg::TGN_IDLE;
      rdata <= 32'h00000000;
    end else if (ce_i) begin
      state <= next_state;
      rdata <= next_rdata;
    end
  end

  assign wb_ack_o = (state == tgn_pkg::TGN_ACK) && req.cyc && req.stb;
  assign wb_dat_o = rdata;

  // Switch decode; T9/T10 routing is owned by another register, so the
  // gain resistor enables here are only meaningful once software has set it
  always_comb begin
    logic [3:0] gcode;
    logic [7:0] ccode;
    logic [7:0] ecode;
    logic [1:0] bcode;
    gcode = regq[0][tgn_pkg::GAIN_RES_LSB +: tgn_pkg::GAIN_RES_W];
    ccode = regq[0][tgn_pkg::FB_CAP_LSB +: tgn_pkg::FB_CAP_W];
    ecode = regq[1][tgn_pkg::ELEC_RES_W-1:0];
    bcode = regq[2][tgn_pkg::BIAS_SEL_W-1:0];
    next_analog = '0;
    if (gcode[3]) begin
      next_analog.gain_res_open = 1'b1;
    end else begin
      next_analog.gain_res_en[gcode[2:0]] = 1'b1;
    end
    next_analog.diode_sw_on = regq[0][tgn_pkg::DIODE_SW_BIT];
    unique case (ccode)
      8'h00: next_analog.fb_cap_pf = tgn_pkg::CAP_1PF;
      8'h01: next_analog.fb_cap_pf = tgn_pkg::CAP_2PF;
      8'h02: next_analog.fb_cap_pf = tgn_pkg::CAP_4PF;
      8'h04: next_analog.fb_cap_pf = tgn_pkg::CAP_8PF;
      8'h08: next_analog.fb_cap_pf = tgn_pkg::CAP_16PF;
      8'h10: next_analog.fb_cap_pf = tgn_pkg::CAP_2PF;
      // Unused and multi-bit codes keep the smallest capacitor as a safe value
      default: begin
        next_analog.fb_cap_pf = tgn_pkg::CAP_1PF;
        next_analog.fb_cap_unused = 1'b1;
      end
    endcase
    next_analog.elec_res_code = ecode;
    next_analog.elec_disconnect = (ecode == tgn_pkg::ELEC_DISCONNECT);
    next_analog.elec_short_both = (ecode == tgn_pkg::ELEC_SHORT_BOTH);
    next_analog.bias_internal_en = (bcode == tgn_pkg::BIAS_INTERNAL);
    next_analog.bias_dac_zero_en = (bcode == tgn_pkg::BIAS_DAC_ZERO);
    next_analog.bias_reserved = bcode[1];
  end

  // Registered so the analog switches never see decode glitches
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      analog <= '0;
    end else if (ce_i) begin
      analog <= next_analog;
    end
  end

  assign analog_o = analog;

endmodule

// File: tgn_config_bank_properties.sv
// Port assertions for the gain network configuration bank.
// Assumes one clock and a synchronous active-high reset.
`timescale 1ns/10ps
module tgn_config_bank_properties (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic ce_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [15:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic wb_ack_o,
  input wire tgn_pkg::tgn_analog_t analog_o
);
  // Decode lags reset release by one edge; checks wait two edges for it
  logic [1:0] up;
  logic [1:0] next_up;
  always_comb begin
    next_up = (up == 2'h2 || !ce_i) ? up : up + 2'h1;
  end
  always_ff @(posedge clk_i) begin
    up <= rst_i ? 2'h0 : next_up;
  end
  default clocking @(posedge clk_i);
  endclocking
  default disable iff (rst_i);
  a_gain_one_hot: assert property (up == 2'h2 |->
    $onehot(analog_o.gain_res_en) ^ analog_o.gain_res_open)
    else $error("gain resistor decode not one-hot or open");
  a_cap_value_legal: assert property (up == 2'h2 && !analog_o.fb_cap_unused
    |-> analog_o.fb_cap_pf inside {5'h01, 5'h02, 5'h04, 5'h08, 5'h10})
    else $error("capacitor value illegal");
  a_bias_one_hot: assert property (up == 2'h2 |-> $onehot({analog_o.bias_internal_en,
    analog_o.bias_dac_zero_en, analog_o.bias_reserved}))
    else $error("bias select decode not one-hot");
  a_short_code: assert property (up == 2'h2 |->
    analog_o.elec_short_both == (analog_o.elec_res_code == 8'h97))
    else $error("short flag wrong");
  a_disconnect_code: assert property (up == 2'h2 |->
    analog_o.elec_disconnect == (analog_o.elec_res_code == 8'hFF))
    else $error("disconnect flag wrong");
  a_reset_decode: assert property ($fell(rst_i) |-> ##1 analog_o.gain_res_open
    && analog_o.elec_disconnect && analog_o.bias_internal_en && analog_o.fb_cap_pf == 5'h01)
    else $error("reset decode wrong");
  a_bias_reserved_zero: assert property (wb_ack_o && !wb_we_i && wb_adr_i == 16'h20FC
    |-> wb_dat_o[31:2] == 30'h0)
    else $error("reserved bits read nonzero");
  a_ack_one_cycle: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o && ce_i
    |=> wb_ack_o ##1 !wb_ack_o)
    else $error("ack timing wrong");
endmodule
bind tgn_config_bank tgn_config_bank_properties chk (.clk_i(clk_i), .rst_i(rst_i), .ce_i(ce_i),
  .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
  .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
  .analog_o(analog_o));

// File: tgn_config_bank_bench.sv
// Self-checking bench for the gain network configuration bank.
// Assumes the bank answers each Wishbone request with one ack.
`timescale 1ns/10ps
module tgn_config_bank_bench;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic ce_i = 1'b1;
  logic wb_cyc_i = 1'b0;
  logic wb_stb_i = 1'b0;
  logic wb_we_i = 1'b0;
  logic [15:0] wb_adr_i = 16'h0000;
  logic [3:0] wb_sel_i = 4'hF;
  logic [31:0] wb_dat_i = 32'h00000000;
  logic [31:0] wb_dat_o;
  logic wb_ack_o;
  tgn_pkg::tgn_analog_t analog_o;
  int miscompares = 0;
  int n_compared = 0;
  logic [31:0] q;
  tgn_config_bank uut (.clk_i(clk_i), .rst_i(rst_i), .ce_i(ce_i), .wb_cyc_i(wb_cyc_i),
    .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i),
    .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .analog_o(analog_o));
  always #2.5 clk_i = ~clk_i;
  task automatic print_verdict;
    if (miscompares == 0 && n_compared > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  task automatic chk(input string s, input logic [31:0] g, input logic [31:0] e);
    n_compared++;
    if (g !== e) begin
      miscompares++;
      $display("CHECK FAILED %s expected %h seen %h", s, e, g);
    end
  endtask
  // Holds the raised request until ack, takes the data and releases on that edge
  task automatic wait_ack;
    int n;
    n = 0;
    do begin
      @(posedge clk_i);
      n++;
    end while (wb_ack_o !== 1'b1 && n < 20);
    if (n >= 20) begin
      miscompares++;
      print_verdict();
    end
    q = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
  endtask
  // One request; the release lands on the ack edge and the next call waits an edge
  task automatic wb(input logic w, input logic [15:0] a, input logic [3:0] s,
                    input logic [31:0] d);
    @(posedge clk_i);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= w;
    wb_adr_i <= a;
    wb_sel_i <= s;
    wb_dat_i <= d;
    wait_ack();
  endtask
  task automatic rd(input string s, input logic [15:0] a, input logic [31:0] e);
    wb(1'b0, a, 4'hF, 32'h00000000);
    chk(s, q, e);
  endtask
  task automatic wr(input logic [15:0] a, input logic [3:0] s, input logic [31:0] d);
    wb(1'b1, a, s, d);
    @(posedge clk_i);
    #1;
  endtask
  task automatic scn_reset_and_masks;
    rd("gain", 16'h20F0, 32'h0000000F);
    rd("path", 16'h20F8, 32'h000000FF);
    rd("bias", 16'h20FC, 32'h00000000);
    wr(16'h2000, 4'hF, 32'hFFFFFFFF);
    rd("unmapped", 16'h2000, 32'h00000000);
    wr(16'h20F0, 4'hF, 32'h00000000);
    wr(16'h20F0, 4'h2, 32'hFFFFFFFF);
    rd("lane", 16'h20F0, 32'h00001F00);
    wr(16'h20F0, 4'hF, 32'hFFFFFFFF);
    rd("gain_mask", 16'h20F0, 32'h00001FFF);
    wr(16'h20F8, 4'hF, 32'hFFFFFF97);
    chk("short", 32'(analog_o.elec_short_both), 32'h1);
    chk("path_code", 32'(analog_o.elec_res_code), 32'h97);
    rd("path_mask", 16'h20F8, 32'h00000097);
    wr(16'h20FC, 4'hF, 32'hFFFFFFFF);
    rd("bias_mask", 16'h20FC, 32'h00000003);
  endtask
  task automatic scn_decode;
    logic [4:0] pf[8] = '{5'h01, 5'h02, 5'h04, 5'h08, 5'h10, 5'h02, 5'h01, 5'h01};
    // The T9/T10 routing lives in another register and is taken as already set
    for (int c = 0; c < 16; c++) begin
      wr(16'h20F0, 4'hF, 32'(c) | (32'(c & 1) << 4));
      chk("res_en", 32'(analog_o.gain_res_en), c < 8 ? 32'h1 << c : 32'h0);
      chk("open", 32'(analog_o.gain_res_open), 32'(c > 7));
      chk("diode", 32'(analog_o.diode_sw_on), 32'(c & 1));
    end
    for (int i = 0; i < 8; i++) begin
      wr(16'h20F0, 4'hF, ((i == 0 ? 32'h0 : 32'h1 << (i - 1)) << 5) | 32'hF);
      chk("cap", 32'(analog_o.fb_cap_pf), 32'(pf[i]));
      chk("unused", 32'(analog_o.fb_cap_unused), 32'(i > 5));
    end
    for (int b = 0; b < 4; b++) begin
      wr(16'h20FC, 4'hF, 32'(b));
      chk("vint", 32'(analog_o.bias_internal_en), 32'(b == 0));
      chk("vdac", 32'(analog_o.bias_dac_zero_en), 32'(b == 1));
      chk("vres", 32'(analog_o.bias_reserved), 32'(b > 1));
    end
  endtask
  // A request held while the enable is low must not be taken or written
  task automatic scn_clock_enable;
    @(posedge clk_i);
    ce_i <= 1'b0;
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= 1'b1;
    wb_adr_i <= 16'h20FC;
    wb_sel_i <= 4'hF;
    wb_dat_i <= 32'h00000001;
    repeat (4) @(posedge clk_i);
    chk("ce_ack", 32'(wb_ack_o), 32'h0);
    ce_i <= 1'b1;
    wait_ack();
    rd("ce_bias", 16'h20FC, 32'h00000001);
    chk("ce_vdac", 32'(analog_o.bias_dac_zero_en), 32'h1);
  endtask
  // Reset in mid-run brings every register and the decode back to reset values
  task automatic scn_mid_reset;
    @(posedge clk_i);
    rst_i <= 1'b1;
    repeat (3) @(posedge clk_i);
    rst_i <= 1'b0;
    rd("gain_rst", 16'h20F0, 32'h0000000F);
    rd("path_rst", 16'h20F8, 32'h000000FF);
    rd("bias_rst", 16'h20FC, 32'h00000000);
    chk("disc_rst", 32'(analog_o.elec_disconnect), 32'h1);
    chk("code_rst", 32'(analog_o.elec_res_code), 32'hFF);
    chk("open_rst", 32'(analog_o.gain_res_open), 32'h1);
    chk("vint_rst", 32'(analog_o.bias_internal_en), 32'h1);
  endtask
  initial begin
    repeat (3) @(posedge clk_i);
    rst_i <= 1'b0;
    scn_reset_and_masks();
    scn_decode();
    scn_clock_enable();
    scn_mid_reset();
    print_verdict();
  end
endmodule
